// ==== rtl/emp_pkg.sv ====
// package of constants and carrier types for the external mii and management port block
package emp_pkg;

    // ****************************************************************
    // register map (byte addresses on the avalon-mm slave)
    // ****************************************************************
    localparam logic [3:0] EMP_CTRL_OFS = 4'h0; // port selects
    localparam logic [3:0] EMP_MGMT_OFS = 4'h4; // management pin drive
    localparam logic [3:0] EMP_STAT_OFS = 4'h8; // read-only status

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int EMP_CTRL_MGMT_SEL_BIT = 0; // external management port select
    localparam int EMP_CTRL_EXT_PHY_BIT = 1; // 1 = external phy, 0 = internal phy
    localparam int EMP_MGMT_DATA_BIT = 0; // level driven on mdio
    localparam int EMP_MGMT_DRIVE_BIT = 1; // mdio output enable request
    localparam int EMP_STAT_STRAP_BIT = 0; // latched external phy detect strap
    localparam int EMP_STAT_STRAP_VLD_BIT = 1; // strap has been captured
    localparam int EMP_STAT_MDIO_BIT = 2; // live mdio level
    localparam int EMP_STAT_CRS_BIT = 3; // carrier sense
    localparam int EMP_STAT_COL_BIT = 4; // collision
    localparam int EMP_STAT_RXDV_BIT = 5; // receive data valid
    localparam int EMP_STAT_RXER_BIT = 6; // receive error

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [1:0] EMP_CTRL_RST = 2'h0; // internal phy, management idle
    localparam logic [1:0] EMP_MGMT_RST = 2'h0; // mdio released

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int EMP_CORE_CLK_NS = 4; // core clock period
    localparam int EMP_MDC_HALF_NS = 200; // management clock half period
    localparam int EMP_MDC_HALF_CYC = EMP_MDC_HALF_NS / EMP_CORE_CLK_NS; // longest, rounds down
    localparam logic [1:0] EMP_STRAP_WAIT = 2'h3; // cycles after release before the strap is taken

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic [3:0] nib; // received nibble
        logic er; // receive error
        logic dv; // receive data valid
        logic crs; // carrier sense
        logic col; // collision
    } emp_rx_t;

    typedef struct packed {
        logic [3:0] nib; // transmit nibble
        logic valid; // nibble is valid
    } emp_tx_t;

endpackage

// ==== rtl/emp_port_top.sv ====
// external mii pins and external management port with avalon-mm control registers
// Contract
// - tx enable only with valid nibble
// - select one: mdio is management data
// - select one drives mdc, zero holds low
// - select zero: mdio released, mdc low
// - mdio also serves as phy detect strap
`timescale 1ns/1ps
`default_nettype none

module emp_port_top
    import emp_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // transmit side, link clock domain
    input wire logic txClk,
    input wire emp_tx_t txIn,
    output logic [3:0] txdOut,
    output logic txEnOut,
    // receive pins from the phy
    input wire logic rxClk,
    input wire logic [3:0] rxdIn,
    input wire logic rxErIn,
    input wire logic rxDvIn,
    input wire logic crsIn,
    input wire logic colIn,
    // received nibbles toward the mac, core domain
    output emp_rx_t rxOut,
    output logic rxStrobe,
    // management pins
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    output logic mdcOut
);

    // ****************************************************************
    // control and status state
    // ****************************************************************
    logic mgmtSel_ff; // external management port select
    logic extPhy_ff; // external phy selected
    logic mgmtDat_ff; // mdio drive level
    logic mgmtDrv_ff; // mdio drive request
    logic ack_ff; // second cycle of a bus access
    logic [31:0] rdData_ff; // read data register
    logic [5:0] mdcCnt_ff; // management clock divider
    logic mdc_ff; // management clock level
    logic [1:0] strapCnt_ff; // wait after reset release
    logic strapVld_ff; // strap captured
    logic strapLatch_ff; // external phy detect strap value
    logic rxClkDly_ff; // previous synced receive clock
    emp_rx_t rx_ff; // captured receive sample
    logic rxStb_ff; // one-cycle capture pulse

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [9:0] pinSync; // rxclk, mdio, rx group after two flops
    emp_rx_t rxSync; // synced receive group
    logic mdioSync; // synced mdio level
    logic rxClkSync; // synced receive clock

    // the nibble is sampled far from its edge, so per-bit skew settles first
    emp_sync #(.WIDTH(10)) uPinSync (
        .syncClk(core_clk),
        .din({rxClk, mdioIn, rxdIn, rxErIn, rxDvIn, crsIn, colIn}),
        .dout(pinSync)
    );

    assign rxClkSync = pinSync[9];
    assign mdioSync = pinSync[8];
    assign rxSync = emp_rx_t'(pinSync[7:0]);

    // ****************************************************************
    // avalon-mm decode
    // ****************************************************************
    wire busReq = avs_read | avs_write; // any request pending
    wire hitCtrl = (avs_address == EMP_CTRL_OFS); // control register
    wire hitMgmt = (avs_address == EMP_MGMT_OFS); // management register
    wire hitStat = (avs_address == EMP_STAT_OFS); // status register
    wire wrTake = avs_write & ack_ff & avs_byteenable[0]; // write takes effect
    wire wrCtrl = wrTake & hitCtrl; // control write
    wire wrMgmt = wrTake & hitMgmt; // management write
    wire rdLoad = avs_read & ~ack_ff; // first cycle of a read

    // every access waits exactly one cycle
    assign avs_waitrequest = busReq & ~ack_ff;
    assign avs_readdata = rdData_ff;

    // status word: live levels plus the latched strap
    wire [31:0] statWord = 32'(
        (32'(strapLatch_ff) << EMP_STAT_STRAP_BIT) |
        (32'(strapVld_ff) << EMP_STAT_STRAP_VLD_BIT) |
        (32'(mdioSync) << EMP_STAT_MDIO_BIT) |
        (32'(rxSync.crs) << EMP_STAT_CRS_BIT) |
        (32'(rxSync.col) << EMP_STAT_COL_BIT) |
        (32'(rxSync.dv) << EMP_STAT_RXDV_BIT) |
        (32'(rxSync.er) << EMP_STAT_RXER_BIT));

    // read mux, unmapped addresses read zero
    wire [31:0] rdMux = hitCtrl ? {30'h0, extPhy_ff, mgmtSel_ff} :
                        hitMgmt ? {30'h0, mgmtDrv_ff, mgmtDat_ff} :
                        hitStat ? statWord : 32'h0;

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    // ack toggles so that back-to-back requests each see one wait cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= busReq & ~ack_ff;
        end
    end

    // read data loaded in the wait cycle, stands at the accepting edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdData_ff <= 32'h0;
        end else if (rdLoad) begin
            rdData_ff <= rdMux;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    // port selects; software writes the low byte lane only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {extPhy_ff, mgmtSel_ff} <= EMP_CTRL_RST;
        end else if (wrCtrl) begin
            mgmtSel_ff <= avs_writedata[EMP_CTRL_MGMT_SEL_BIT];
            extPhy_ff <= avs_writedata[EMP_CTRL_EXT_PHY_BIT];
        end
    end

    // management pin level and drive request
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {mgmtDrv_ff, mgmtDat_ff} <= EMP_MGMT_RST;
        end else if (wrMgmt) begin
            mgmtDat_ff <= avs_writedata[EMP_MGMT_DATA_BIT];
            mgmtDrv_ff <= avs_writedata[EMP_MGMT_DRIVE_BIT];
        end
    end

    // ****************************************************************
    // management port pins
    // ****************************************************************
    // mdio only leaves high impedance while the port is selected
    assign mdioOe = mgmtSel_ff & mgmtDrv_ff;
    assign mdioOut = mgmtSel_ff & mgmtDat_ff;
    assign mdcOut = mdc_ff;

    wire mdcWrap = (mdcCnt_ff == 6'(EMP_MDC_HALF_CYC - 1)); // half period done
    wire [5:0] nxt_mdcCnt = (~mgmtSel_ff | mdcWrap) ? 6'h0 : 6'(mdcCnt_ff + 6'h1);
    // select as it stands after this edge, so mdc drops in the same cycle as the select
    wire nxt_mgmtSel = wrCtrl ? avs_writedata[EMP_CTRL_MGMT_SEL_BIT] : mgmtSel_ff;
    wire nxt_mdc = nxt_mgmtSel & (mdcWrap ? ~mdc_ff : mdc_ff);

    // free-running divider, cleared and held low while deselected
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mdcCnt_ff <= 6'h0;
            mdc_ff <= 1'b0;
        end else begin
            mdcCnt_ff <= nxt_mdcCnt;
            mdc_ff <= nxt_mdc;
        end
    end

    // ****************************************************************
    // external phy detect strap
    // ****************************************************************
    // mdio is released during reset, so the pin shows the strap level;
    // the wait lets the synchroniser flush before the value is taken
    wire strapTake = ~strapVld_ff & (strapCnt_ff == EMP_STRAP_WAIT);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            strapCnt_ff <= 2'h0;
            strapVld_ff <= 1'b0;
            strapLatch_ff <= 1'b0;
        end else if (strapTake) begin
            strapVld_ff <= 1'b1;
            strapLatch_ff <= mdioSync;
        end else if (~strapVld_ff) begin
            strapCnt_ff <= 2'(strapCnt_ff + 2'h1);
        end
    end

    // ****************************************************************
    // receive capture
    // ****************************************************************
    // the phy's receive signals are stable around its clock's rising edge;
    // limitation: needs the core clock well above the receive clock
    wire rxRise = rxClkSync & ~rxClkDly_ff; // receive clock rose

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxClkDly_ff <= 1'b0;
            rx_ff <= '0;
            rxStb_ff <= 1'b0;
        end else begin
            rxClkDly_ff <= rxClkSync;
            rxStb_ff <= rxRise & extPhy_ff;
            if (rxRise & extPhy_ff) begin
                rx_ff <= rxSync;
            end
        end
    end

    assign rxOut = rx_ff;
    assign rxStrobe = rxStb_ff;

    // ****************************************************************
    // transmit side on the link clock
    // ****************************************************************
    logic [1:0] txCross; // reset and phy select after two flops
    logic rstTx; // reset seen in the link domain
    logic extPhyTx; // phy select seen in the link domain
    logic [3:0] txd_ff; // transmit nibble register
    logic txEn_ff; // transmit enable register

    emp_sync #(.WIDTH(2)) uTxSync (
        .syncClk(txClk),
        .din({sys_rst, extPhy_ff}),
        .dout(txCross)
    );

    assign rstTx = txCross[1];
    assign extPhyTx = txCross[0];

    wire txPass = extPhyTx & txIn.valid; // nibble goes to the phy
    wire [3:0] nxt_txd = txPass ? txIn.nib : 4'h0;
    wire nxt_txEn = txPass;

    // both pins sit low unless a valid nibble goes to the external phy
    always_ff @(posedge txClk) begin
        if (rstTx) begin
            txd_ff <= 4'h0;
            txEn_ff <= 1'b0;
        end else begin
            txd_ff <= nxt_txd;
            txEn_ff <= nxt_txEn;
        end
    end

    assign txdOut = txd_ff;
    assign txEnOut = txEn_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence ctrlClearSel_s;
        wrCtrl && !avs_writedata[EMP_CTRL_MGMT_SEL_BIT];
    endsequence

    sequence strapReady_s;
        !strapVld_ff && strapCnt_ff == EMP_STRAP_WAIT;
    endsequence

    txdInternal_a: assert property (@(posedge txClk) disable iff (rstTx)
        !extPhyTx |=> txdOut == 4'h0)
        else $error("transmit nibble not low with internal phy");

    txdFollow_a: assert property (@(posedge txClk) disable iff (rstTx)
        txPass |=> txdOut == $past(txIn.nib) && txEnOut)
        else $error("transmit nibble not passed through");

    txEnGate_a: assert property (@(posedge txClk) disable iff (rstTx)
        !(extPhyTx && txIn.valid) |=> !txEnOut)
        else $error("transmit enable without valid nibble");

    mdioRelease_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ctrlClearSel_s |=> !mdioOe && !mdcOut)
        else $error("mdio or mdc active after deselect");

    mdioDrive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        mgmtSel_ff && wrMgmt && avs_writedata[1:0] == 2'h3 |=> mdioOe && mdioOut)
        else $error("mdio not driven when requested");

    mdcToggle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        mgmtSel_ff && mdcWrap && !wrCtrl |=> mdcOut != $past(mdcOut))
        else $error("management clock missed its edge");

    mdcSteady_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        mgmtSel_ff && !mdcWrap && !wrCtrl |=> $stable(mdcOut))
        else $error("management clock toggled early");

    strapTake_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        strapReady_s |=> strapVld_ff && strapLatch_ff == $past(mdioSync))
        else $error("strap not latched from mdio");

    strapHold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        strapVld_ff |=> strapVld_ff && $stable(strapLatch_ff))
        else $error("latched strap changed before reset");

    busWait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        busReq && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");

endmodule

`default_nettype wire

// ==== rtl/emp_sync.sv ====
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none

module emp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic syncClk,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ****************************************************************
    // two stages, the first is read by the second only
    // ****************************************************************
    logic [WIDTH-1:0] meta_ff; // may go metastable
    logic [WIDTH-1:0] sync_ff; // settled copy

    // no reset: the chain flushes itself within two edges
    always_ff @(posedge syncClk) begin
        meta_ff <= din;
        sync_ff <= meta_ff;
    end

    assign dout = sync_ff;

endmodule

`default_nettype wire

// ==== testbench/emp_phy_model.sv ====
// external phy model: free-running mii clocks and receive pins
`timescale 1ns/1ps
`default_nettype none

module emp_phy_model (
    output logic txClk,
    output logic rxClk,
    output logic [3:0] rxd,
    output logic rxEr,
    output logic rxDv,
    output logic crs,
    output logic col
);
    // ****************************************************************
    // clocks
    // ****************************************************************
    // tx at the bench link rate, rx at 25 MHz, both free-running
    initial txClk = 1'b0;
    always #7.5 txClk = ~txClk;
    initial rxClk = 1'b0;
    always #20 rxClk = ~rxClk;

    // idle levels: rxd[3:1] pulled down, the rest low
    initial begin
        rxd = 4'h0;
        rxEr = 1'b0;
        rxDv = 1'b0;
        crs = 1'b0;
        col = 1'b0;
    end

    // ****************************************************************
    // one received nibble, launched on the falling rx clock edge
    // ****************************************************************
    task automatic send_frame(input logic [3:0] nib, input logic er, input logic c);
        @(negedge rxClk);
        rxd = nib;
        rxDv = 1'b1;
        crs = 1'b1;
        rxEr = er;
        col = c;
        @(negedge rxClk);
        // rxd0 has no pull-down, so it must not keep the old level
        rxd = {3'h0, ~nib[0]};
        rxDv = 1'b0;
        crs = 1'b0;
        rxEr = 1'b0;
        col = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the external mii and management port block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import emp_pkg::*;
    logic core_clk; // 250 MHz core clock
    logic sys_rst; // synchronous reset
    logic [3:0] avsAddress;
    logic avsRead;
    logic avsWrite;
    logic [31:0] avsWritedata;
    logic [3:0] avsByteenable;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic txClk;
    logic rxClk;
    emp_tx_t txIn; // transmit request, txClk domain
    logic [3:0] txdOut;
    logic txEnOut;
    logic [3:0] rxd;
    logic rxEr, rxDv, crs, col;
    emp_rx_t rxOut;
    logic rxStrobe;
    logic mdioIn, mdioOut, mdioOe, mdcOut;
    logic phyPull; // strap resistor of an attached phy
    logic phyDrv; // level the phy drives on mdio
    logic phyDrvEn; // phy drives mdio
    logic [31:0] rdVal;
    int err_count;
    int total_checks;
    int cnt;

    // mdio wire: device first, then phy, else the strap resistor
    assign mdioIn = mdioOe ? mdioOut : (phyDrvEn ? phyDrv : phyPull);

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    emp_phy_model i_phy (.txClk(txClk), .rxClk(rxClk), .rxd(rxd), .rxEr(rxEr), .rxDv(rxDv), .crs(crs), .col(col));

    emp_port_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .txClk(txClk), .txIn(txIn),
        .txdOut(txdOut), .txEnOut(txEnOut), .rxClk(rxClk), .rxdIn(rxd), .rxErIn(rxEr), .rxDvIn(rxDv),
        .crsIn(crs), .colIn(col), .rxOut(rxOut), .rxStrobe(rxStrobe), .mdioIn(mdioIn), .mdioOut(mdioOut),
        .mdioOe(mdioOe), .mdcOut(mdcOut));

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // avalon-mm master: hold until waitrequest is seen low at an edge
    // ****************************************************************
    task automatic bus_xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avsAddress <= adr;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWritedata <= wd;
        avsByteenable <= be;
        // waitrequest and read data are both taken at the accepting edge
        do begin
            @(posedge core_clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 50);
        rdVal = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        chk(n < 50, 1'b1, "bus answer");
    endtask

    // masked register read compare
    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] mask, input logic [31:0] exp);
        bus_xfer(1'b0, adr, 32'h0, 4'hF);
        chk(rdVal & mask, exp, "register read");
    endtask

    // one nibble offered at a tx clock edge, pins seen one edge later
    task automatic tx_nib(input logic [4:0] v, input logic [4:0] exp);
        @(posedge txClk);
        txIn <= v;
        @(posedge txClk);
        @(negedge txClk);
        chk({txdOut, txEnOut}, exp, "tx pins");
    endtask

    // a received nibble must reach rxOut with its strobe
    task automatic rx_case(input logic [3:0] nib, input logic er, input logic c);
        emp_rx_t got;
        int seen;
        seen = 0;
        got = '0;
        fork
            i_phy.send_frame(nib, er, c);
            repeat (30) begin
                @(negedge core_clk);
                if (rxStrobe === 1'b1 && rxOut.dv === 1'b1) begin
                    seen++;
                    got = rxOut;
                end
            end
        join
        chk(seen > 0, 1'b1, "rx strobe");
        chk(got, {nib, er, 1'b1, 1'b1, c}, "rx nibble");
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask

    // count mdc high cycles over a window
    task automatic mdc_high(input int span);
        cnt = 0;
        repeat (span) begin
            @(negedge core_clk);
            if (mdcOut !== 1'b0) cnt++;
        end
    endtask

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        sys_rst = 1'b1;
        avsAddress = 4'h0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0;
        avsByteenable = 4'h0;
        txIn = '0;
        phyPull = 1'b1;
        phyDrv = 1'b0;
        phyDrvEn = 1'b0;
        err_count = 0;
        total_checks = 0;
        do_reset();
        // reset state: internal phy, management idle, strap taken
        rd_chk(EMP_CTRL_OFS, 32'h3, 32'h0);
        rd_chk(EMP_STAT_OFS, 32'h3, 32'h3);
        @(negedge core_clk);
        chk({mdioOe, mdcOut}, 2'h0, "mgmt idle");
        // internal phy: tx pins held low whatever is offered
        tx_nib(5'h1F, 5'h00);
        // refused accesses leave registers as they were
        bus_xfer(1'b1, EMP_CTRL_OFS, 32'h3, 4'hE);
        rd_chk(EMP_CTRL_OFS, 32'h3, 32'h0);
        bus_xfer(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
        bus_xfer(1'b1, EMP_STAT_OFS, 32'h0, 4'hF);
        rd_chk(EMP_STAT_OFS, 32'h3, 32'h3);
        // external phy: nibbles pass, enable only with valid
        bus_xfer(1'b1, EMP_CTRL_OFS, 32'h2, 4'hF);
        repeat (4) @(posedge txClk);
        tx_nib(5'h15, 5'h15);
        tx_nib(5'h1F, 5'h1F);
        tx_nib(5'h01, 5'h01);
        tx_nib(5'h1E, 5'h00);
        rx_case(4'h5, 1'b0, 1'b1);
        rx_case(4'hA, 1'b1, 1'b0);
        // management port on: mdio driven both ways, mdc runs; resistor low so levels tell
        phyPull <= 1'b0;
        bus_xfer(1'b1, EMP_CTRL_OFS, 32'h3, 4'hF);
        bus_xfer(1'b1, EMP_MGMT_OFS, 32'h3, 4'hF);
        @(negedge core_clk);
        chk({mdioOe, mdioOut}, 2'h3, "mdio drive");
        // let the level pass the pin synchroniser before reading it back
        repeat (3) @(posedge core_clk);
        rd_chk(EMP_STAT_OFS, 32'h4, 32'h4);
        bus_xfer(1'b1, EMP_MGMT_OFS, 32'h0, 4'hF);
        phyDrvEn <= 1'b1;
        phyDrv <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd_chk(EMP_STAT_OFS, 32'h4, 32'h4);
        phyDrvEn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd_chk(EMP_STAT_OFS, 32'h4, 32'h0);
        // wait for mdc low first, so the high phase is seen from its start
        cnt = 0;
        @(negedge core_clk);
        while (mdcOut !== 1'b0 && cnt < 4 * EMP_MDC_HALF_CYC) begin
            @(negedge core_clk);
            cnt++;
        end
        cnt = 0;
        while (mdcOut !== 1'b1 && cnt < 4 * EMP_MDC_HALF_CYC) begin
            @(negedge core_clk);
            cnt++;
        end
        chk(mdcOut, 1'b1, "mdc toggles");
        cnt = 0;
        while (mdcOut === 1'b1 && cnt < 4 * EMP_MDC_HALF_CYC) begin
            @(negedge core_clk);
            cnt++;
        end
        chk(cnt, EMP_MDC_HALF_CYC, "mdc half period");
        // management port off with drive requested: pin released, mdc low
        bus_xfer(1'b1, EMP_MGMT_OFS, 32'h3, 4'hF);
        bus_xfer(1'b1, EMP_CTRL_OFS, 32'h2, 4'hF);
        @(negedge core_clk);
        chk({mdioOe, mdioOut, mdcOut}, 3'h0, "mdio released");
        mdc_high(3 * EMP_MDC_HALF_CYC);
        chk(cnt, 0, "mdc held low");
        // strap held until the next reset, then taken again with the resistor low
        rd_chk(EMP_STAT_OFS, 32'h3, 32'h3);
        do_reset();
        rd_chk(EMP_STAT_OFS, 32'h3, 32'h2);
        rd_chk(EMP_CTRL_OFS, 32'h3, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
